// ### asr_assertions.sv
// port-level checks for the converter sequencer block
`timescale 1ns/1ps
module asr_checker
	import asr_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        global_irq_enable,
	input wire logic        done_irq,
	input wire logic        conv_power_on,
	input wire logic        conv_clk_tick,
	input wire logic        conv_start,
	input wire logic        conv_busy,
	input wire logic        sel_differential,
	input wire logic        sel_bandgap,
	input wire logic        sel_ground,
	input wire asr_gain_t   sel_gain
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==========
	// assertions
	chk_irq_gate: assert property (done_irq |-> global_irq_enable)
		else $error("irq without global enable");
	chk_off_idle: assert property (!conv_power_on |-> !conv_busy)
		else $error("busy while converter off");
	chk_start_busy: assert property (conv_start |-> conv_busy && conv_power_on)
		else $error("start pulse outside conversion");
	chk_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	chk_conv_min: assert property ($rose(conv_busy) |-> conv_busy[*3])
		else $error("conversion too short");
	chk_tick_pulse: assert property (conv_clk_tick |=> !conv_clk_tick)
		else $error("tick faster than half rate");
	chk_ground_alone: assert property (sel_ground |-> !sel_bandgap && !sel_differential)
		else $error("ground select overlaps");
	chk_diff_gain: assert property (sel_differential == (sel_gain != ASR_GAIN_NONE))
		else $error("gain and pair disagree");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	chk_read_upper: assert property (prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	// ==========
	// coverage
	cover property ($fell(conv_busy) && conv_power_on);
	cover property (done_irq);
	cover property (pslverr);
endmodule

bind asr_core asr_checker u_chk (.sys_clk, .rst, .psel, .penable, .prdata, .pslverr,
	.global_irq_enable, .done_irq, .conv_power_on, .conv_clk_tick, .conv_start,
	.conv_busy, .sel_differential, .sel_bandgap, .sel_ground, .sel_gain);

// ### asr_conv_model.sv
// analogue core stand-in giving a fresh result per conversion
`timescale 1ns/1ps
module asr_conv_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       conv_start,
	input  wire logic       conv_busy,
	output logic      [9:0] conversion_value_in
);
	logic [9:0] val_q;
	always_ff @(posedge sys_clk) begin
		if (rst)
			val_q <= 10'h2C5;
		else if (conv_start)
			val_q <= val_q + 10'h0A7;
	end
	// result only valid while converting
	assign conversion_value_in = conv_busy ? val_q : ~val_q;
endmodule

// ### asr_core.sv
// converter sequencer, clock divider, apb registers and result register
`timescale 1ns/1ps

// Summary of operation
// - select changes apply only after the running conversion completes
// - codes 0..7 pick single inputs 0..7; 11110 bandgap, 11111 ground
// - codes 01000..11101 pick differential pair and gain per table
// - converter_on enables converter; clearing it aborts a running conversion
// - writing go starts single conversion or first free-running conversion
// - first conversion after enable takes 25 converter clocks, others 13
// - go reads one while converting, zero after; writing zero ignored
// - auto trigger starts conversion on rising edge of selected trigger
// - done flag sets when conversion finishes and result is updated
// - interrupt requested when flag, irq enable and global enable set
// - flag clears on vector acknowledge or software write of one
// - divider select: 000/001 divide by 2, then 4 up to 128
// - reading low byte freezes result until high byte is read
// - left justify: high=9:2, low 7:6=1:0; right: high 1:0=9:8
// - result resets to right justification
// - justification change affects result presentation immediately
// - trigger select chooses edge source; value 0 is free running
module asr_core
	import asr_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  trigger_in,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_vector_ack,
	input  wire logic [9:0]  conversion_value_in,
	output logic             done_irq,
	output logic             conv_power_on,
	output logic             conv_clk_tick,
	output logic             conv_start,
	output logic             conv_busy,
	output logic             sel_differential,
	output logic             sel_bandgap,
	output logic             sel_ground,
	output logic      [2:0]  sel_pos_input,
	output logic      [2:0]  sel_neg_input,
	output asr_gain_t        sel_gain
);

	// ==================================================
	// register state
	logic        on_q, auto_q, done_q, irq_en_q, ljust_q;
	logic [2:0]  div_q, tss_q;
	logic [4:0]  sel_q, active_sel_q;
	logic        busy_q, first_q, lock_q, trig_prev_q;
	logic [6:0]  pre_cnt_q;
	logic [4:0]  conv_cnt_q, conv_len_q;
	logic [9:0]  result_q;
	logic [31:0] prdata_q;
	logic        tick_q, start_q;

	logic        wr_acc, rd_acc, rd_setup;
	logic        wr_ctrl, wr_sel, wr_sfn;
	logic        rd_lo, rd_hi;
	logic        go_wr, turn_on, trig_level, trig_edge, free_run;
	logic        finish, launch, shut_off, store;
	logic [6:0]  div_last;
	logic [7:0]  res_lo, res_hi;
	logic        mapped;

	assign wr_acc   = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr_ctrl  = wr_acc & (paddr[4:0] == ASR_OFF_CTRL_STATUS);
	assign wr_sel   = wr_acc & (paddr[4:0] == ASR_OFF_INPUT_SEL);
	assign wr_sfn   = wr_acc & (paddr[4:0] == ASR_OFF_SPECIAL_FN);
	// low byte locks at the edge that captures its read data
	assign rd_lo    = rd_setup & (paddr[4:0] == ASR_OFF_RESULT_LO);
	assign rd_hi    = rd_acc & (paddr[4:0] == ASR_OFF_RESULT_HI);
	assign mapped   = (paddr[31:5] == 27'h0000000) & (paddr[1:0] == 2'h0)
		& (paddr[4:2] <= 3'h4);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_q;

	// ==================================================
	// start sources
	// enable rising edge
	assign turn_on = wr_ctrl & pwdata[ASR_BIT_ON] & ~on_q;
	assign go_wr = wr_ctrl & pwdata[ASR_BIT_GO] & pwdata[ASR_BIT_ON];
	// trigger select, zero has no edge
	assign trig_level = (tss_q == 3'h0) ? 1'b0 : trigger_in[tss_q];
	assign trig_edge = auto_q & trig_level & ~trig_prev_q;
	assign free_run  = auto_q & (tss_q == 3'h0);

	always_comb begin
		case (div_q)
			3'h0, 3'h1: div_last = 7'h01;
			3'h2:       div_last = 7'h03;
			3'h3:       div_last = 7'h07;
			3'h4:       div_last = 7'h0F;
			3'h5:       div_last = 7'h1F;
			3'h6:       div_last = 7'h3F;
			default:    div_last = 7'h7F;
		endcase
	end

	assign finish = busy_q & tick_q & (conv_cnt_q == conv_len_q - 5'h01);
	// a disable write also cancels a launch in the same cycle
	assign shut_off = wr_ctrl & ~pwdata[ASR_BIT_ON];
	assign launch = ~shut_off
		& ((on_q & ((~busy_q & (go_wr | trig_edge)) | (finish & free_run)))
		| (~on_q & go_wr));

	// ==================================================
	// software registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			on_q     <= 1'b0;
			auto_q   <= 1'b0;
			irq_en_q <= 1'b0;
			div_q    <= 3'h0;
		end else if (wr_ctrl) begin
			on_q     <= pwdata[ASR_BIT_ON];
			auto_q   <= pwdata[ASR_BIT_AUTO];
			irq_en_q <= pwdata[ASR_BIT_IRQ_EN];
			div_q    <= pwdata[ASR_DIV_MSB:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ljust_q <= 1'b0;
			sel_q   <= 5'h00;
		end else if (wr_sel) begin
			ljust_q <= pwdata[ASR_BIT_LJUST];
			sel_q   <= pwdata[ASR_SEL_MSB:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tss_q       <= 3'h0;
			trig_prev_q <= 1'b0;
		end else begin
			if (wr_sfn)
				tss_q <= pwdata[ASR_TSS_LSB+2:ASR_TSS_LSB];
			trig_prev_q <= trig_level;
		end
	end

	// ==================================================
	// prescaler
	always_ff @(posedge sys_clk) begin
		if (rst || !on_q || launch) begin
			pre_cnt_q <= 7'h00;
			tick_q    <= 1'b0;
		end else if (pre_cnt_q == div_last) begin
			pre_cnt_q <= 7'h00;
			tick_q    <= 1'b1;
		end else begin
			pre_cnt_q <= pre_cnt_q + 7'h01;
			tick_q    <= 1'b0;
		end
	end

	// ==================================================
	// conversion sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_q     <= 1'b0;
			first_q    <= 1'b0;
			conv_cnt_q <= 5'h00;
			conv_len_q <= ASR_NORMAL_CONV_CYCLES;
			start_q    <= 1'b0;
		end else begin
			start_q <= launch;
			if (turn_on)
				first_q <= 1'b1;
			if (wr_ctrl && !pwdata[ASR_BIT_ON]) begin
				busy_q <= 1'b0;
			end else if (launch) begin
				busy_q     <= 1'b1;
				conv_cnt_q <= 5'h00;
				conv_len_q <= (first_q || turn_on) ? ASR_FIRST_CONV_CYCLES
					: ASR_NORMAL_CONV_CYCLES;
				first_q    <= 1'b0;
			end else if (finish) begin
				busy_q <= 1'b0;
			end else if (busy_q && tick_q) begin
				conv_cnt_q <= conv_cnt_q + 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			active_sel_q <= 5'h00;
		else if (!busy_q || finish)
			active_sel_q <= wr_sel ? pwdata[ASR_SEL_MSB:0] : sel_q;
	end

	// ==================================================
	// result, lock and flag
	// low read locks, high read unlocks
	always_ff @(posedge sys_clk) begin
		if (rst)
			lock_q <= 1'b0;
		else if (rd_hi)
			lock_q <= 1'b0;
		else if (rd_lo)
			lock_q <= 1'b1;
	end

	// low-byte capture cycle also blocks, keeping the byte pair coherent
	assign store = finish & ~lock_q & ~rd_lo;

	always_ff @(posedge sys_clk) begin
		if (rst)
			result_q <= 10'h000;
		else if (store)
			result_q <= conversion_value_in;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			done_q <= 1'b0;
		else if (store)
			done_q <= 1'b1;
		// clear by vector or write one
		else if (irq_vector_ack || (wr_ctrl && pwdata[ASR_BIT_DONE]))
			done_q <= 1'b0;
	end

	assign done_irq = done_q & irq_en_q & global_irq_enable;

	assign res_hi = ljust_q ? result_q[9:2] : {6'h00, result_q[9:8]};
	assign res_lo = ljust_q ? {result_q[1:0], 6'h00} : result_q[7:0];

	// ==================================================
	// read data, captured in the setup cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_q <= 32'h00000000;
		end else if (rd_setup) begin
			case (paddr[4:0])
				ASR_OFF_CTRL_STATUS: prdata_q <= {24'h000000, on_q, busy_q, auto_q,
					done_q, irq_en_q, div_q};
				ASR_OFF_INPUT_SEL:   prdata_q <= {26'h0000000, ljust_q, sel_q};
				ASR_OFF_RESULT_LO:   prdata_q <= {24'h000000, res_lo};
				ASR_OFF_RESULT_HI:   prdata_q <= {24'h000000, res_hi};
				ASR_OFF_SPECIAL_FN:  prdata_q <= {24'h000000, tss_q, 5'h00};
				default:             prdata_q <= 32'h00000000;
			endcase
		end
	end

	// ==================================================
	// analogue side
	assign conv_power_on = on_q;
	assign conv_clk_tick = tick_q;
	assign conv_start    = start_q;
	assign conv_busy     = busy_q;

	always_comb begin
		sel_differential = 1'b0;
		sel_bandgap      = 1'b0;
		sel_ground       = 1'b0;
		sel_pos_input    = active_sel_q[2:0];
		sel_neg_input    = 3'h0;
		sel_gain         = ASR_GAIN_NONE;
		if (active_sel_q == ASR_SEL_BANDGAP) begin
			sel_bandgap = 1'b1;
		end else if (active_sel_q == ASR_SEL_GROUND) begin
			sel_ground = 1'b1;
		end else if (active_sel_q > ASR_SEL_LAST_SINGLE) begin
			sel_differential = 1'b1;
			if (active_sel_q[4] == 1'b0) begin
				sel_pos_input = {1'b0, active_sel_q[2], active_sel_q[0]};
				sel_neg_input = {1'b0, active_sel_q[2], 1'b0};
				sel_gain      = active_sel_q[1] ? ASR_GAIN_200X : ASR_GAIN_10X;
			end else begin
				sel_pos_input = active_sel_q[2:0];
				sel_neg_input = active_sel_q[3] ? 3'h2 : 3'h1;
				sel_gain      = ASR_GAIN_1X;
			end
		end
	end

endmodule

// ### asr_core_test.sv
// self-checking bench for the converter sequencer block
`timescale 1ns/1ps
module asr_core_test;
	import asr_pkg::*;
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic        global_irq_enable, irq_vector_ack, done_irq, conv_power_on;
	logic        conv_clk_tick, conv_start, conv_busy, sel_differential, sel_bandgap, sel_ground;
	logic [31:0] paddr, pwdata, prdata;
	logic [7:0]  trigger_in, q;
	logic [9:0]  conversion_value_in, v, w;
	logic [2:0]  sel_pos_input, sel_neg_input;
	asr_gain_t   sel_gain;
	int          bad_count, total_checks, t;
	asr_core u_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .trigger_in, .global_irq_enable, .irq_vector_ack,
		.conversion_value_in, .done_irq, .conv_power_on, .conv_clk_tick, .conv_start,
		.conv_busy, .sel_differential, .sel_bandgap, .sel_ground, .sel_pos_input,
		.sel_neg_input, .sel_gain);
	asr_conv_model u_ana (.sys_clk, .rst, .conv_start, .conv_busy, .conversion_value_in);
	always #25 sys_clk = ~sys_clk;
	// ==========
	// helpers
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {27'h0, a};
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1) @(posedge sys_clk);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] x, input string n);
		bus(1'h0, a, 8'h00);
		chk(n, q, x);
	endtask
	task automatic fin;
		t = 0;
		for (int i = 0; i < 9000; i++) begin
			@(posedge sys_clk);
			if (conv_busy === 1'h1) t += conv_clk_tick;
			else if (i > 0) break;
		end
		v = u_ana.val_q;
	endtask
	task automatic conclude;
		if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		for (int a = 0; a < 5; a++) rdc(5'(a * 4), 8'h00, "reset reg");
		bus(1'h0, 5'h14, 8'h00);
		chk("unmapped", {e, q}, 9'h100);
	endtask
	task automatic t_select;
		logic [4:0] c;
		logic       d;
		asr_gain_t  g;
		for (int i = 0; i < 32; i++) begin
			c = 5'(i);
			d = c > 5'h07 && c < 5'h1E;
			g = !d ? ASR_GAIN_NONE : c[4] ? ASR_GAIN_1X : c[1] ? ASR_GAIN_200X : ASR_GAIN_10X;
			bus(1'h1, ASR_OFF_INPUT_SEL, {3'h0, c});
			@(posedge sys_clk);
			chk("diff", sel_differential, d);
			chk("gain", sel_gain, g);
			chk("bandgap", sel_bandgap, c == 5'h1E);
			chk("ground", sel_ground, c == 5'h1F);
			if (c < 5'h1E) chk("pos", sel_pos_input, c[4] || !d ? c[2:0] : {1'h0, c[2], c[0]});
			if (d) chk("neg", sel_neg_input, c[4] ? {c[3], ~c[3], 1'h0} >> 1 : {c[2], 1'h0});
		end
		bus(1'h1, ASR_OFF_INPUT_SEL, 8'h00);
	endtask
	task automatic t_conv;
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hC0);
		fin;
		chk("first len", t, 25);
		rdc(ASR_OFF_CTRL_STATUS, 8'h90, "ctrl done");
		rdc(ASR_OFF_RESULT_LO, v[7:0], "lo right");
		rdc(ASR_OFF_RESULT_HI, {6'h0, v[9:8]}, "hi right");
		bus(1'h1, ASR_OFF_INPUT_SEL, 8'h20);
		rdc(ASR_OFF_RESULT_LO, {v[1:0], 6'h00}, "lo left");
		rdc(ASR_OFF_RESULT_HI, v[9:2], "hi left");
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hC0);
		bus(1'h1, ASR_OFF_INPUT_SEL, 8'h03);
		@(posedge sys_clk);
		chk("held sel", sel_pos_input, 3'h0);
		fin;
		chk("new sel", sel_pos_input, 3'h3);
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'h90);
		rdc(ASR_OFF_CTRL_STATUS, 8'h80, "flag clr");
		rdc(ASR_OFF_RESULT_LO, v[7:0], "lo lock");
		w = v;
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hC0);
		fin;
		chk("next len", t, 13);
		rdc(ASR_OFF_CTRL_STATUS, 8'h80, "blocked flag");
		rdc(ASR_OFF_RESULT_LO, w[7:0], "lo held");
		rdc(ASR_OFF_RESULT_HI, {6'h0, w[9:8]}, "hi held");
	endtask
	task automatic t_irq;
		global_irq_enable <= 1'h1;
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hC8);
		fin;
		@(posedge sys_clk);
		chk("irq on", done_irq, 1'h1);
		irq_vector_ack <= 1'h1;
		@(posedge sys_clk);
		irq_vector_ack <= 1'h0;
		@(posedge sys_clk);
		chk("irq ack", done_irq, 1'h0);
	endtask
	task automatic t_abort;
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hC0);
		@(posedge sys_clk);
		chk("power on", conv_power_on, 1'h1);
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'h00);
		repeat (40) @(posedge sys_clk);
		chk("power off", conv_power_on, 1'h0);
		rdc(ASR_OFF_CTRL_STATUS, 8'h00, "abort");
	endtask
	task automatic t_div;
		for (int k = 0; k < 8; k++) begin
			bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hC0 | 8'(k));
			for (int i = 0; i < 300 && conv_clk_tick !== 1'h1; i++) @(posedge sys_clk);
			t = 0;
			do begin
				@(posedge sys_clk);
				t++;
			end while (t < 300 && conv_clk_tick !== 1'h1);
			chk("divide", t, k < 2 ? 2 : 1 << k);
			bus(1'h1, ASR_OFF_CTRL_STATUS, 8'h00);
		end
	endtask
	task automatic t_trig;
		bus(1'h1, ASR_OFF_SPECIAL_FN, 8'h20);
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hA0);
		trigger_in <= 8'h02;
		repeat (2) @(posedge sys_clk);
		chk("trig busy", conv_busy, 1'h1);
		fin;
		chk("trig len", t, 25);
		bus(1'h1, ASR_OFF_SPECIAL_FN, 8'h00);
		@(posedge sys_clk);
		chk("free switch", conv_busy, 1'h0);
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'hE0);
		t = 0;
		repeat (60) begin
			@(posedge sys_clk);
			t += conv_start;
		end
		chk("free starts", t, 3);
		chk("free rerun", conv_busy, 1'h1);
		bus(1'h1, ASR_OFF_CTRL_STATUS, 8'h00);
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		conclude;
	end
	initial begin
		{sys_clk, psel, penable, pwrite, global_irq_enable, irq_vector_ack} = 6'h00;
		{paddr, pwdata, trigger_in, bad_count, total_checks} = '0;
		rst = 1'h1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		t_reset;
		t_select;
		t_conv;
		t_irq;
		t_abort;
		t_div;
		t_trig;
		conclude;
	end
endmodule

// ### asr_pkg.sv
// constants for the converter sequencer and result register block
package asr_pkg;

	// ==================================================
	// register byte addresses on the apb side
	localparam logic [4:0] ASR_OFF_CTRL_STATUS = 5'h00;
	localparam logic [4:0] ASR_OFF_INPUT_SEL   = 5'h04;
	localparam logic [4:0] ASR_OFF_RESULT_LO   = 5'h08;
	localparam logic [4:0] ASR_OFF_RESULT_HI   = 5'h0C;
	localparam logic [4:0] ASR_OFF_SPECIAL_FN  = 5'h10;

	// ==================================================
	// converter_control_status fields
	localparam int ASR_BIT_ON      = 7;
	localparam int ASR_BIT_GO      = 6;
	localparam int ASR_BIT_AUTO    = 5;
	localparam int ASR_BIT_DONE    = 4;
	localparam int ASR_BIT_IRQ_EN  = 3;
	localparam int ASR_DIV_MSB     = 2;

	// input_select_reg fields
	localparam int ASR_BIT_LJUST   = 5;
	localparam int ASR_SEL_MSB     = 4;

	// special_function_reg fields
	localparam int ASR_TSS_LSB     = 5;

	// ==================================================
	// reset values
	localparam logic [7:0] ASR_RST_REG = 8'h00;

	// ==================================================
	// conversion lengths in converter clock cycles
	localparam logic [4:0] ASR_FIRST_CONV_CYCLES  = 5'h19;
	localparam logic [4:0] ASR_NORMAL_CONV_CYCLES = 5'h0D;

	// ==================================================
	// select code landmarks
	localparam logic [4:0] ASR_SEL_LAST_SINGLE = 5'h07;
	localparam logic [4:0] ASR_SEL_LAST_DIFF   = 5'h1D;
	localparam logic [4:0] ASR_SEL_BANDGAP     = 5'h1E;
	localparam logic [4:0] ASR_SEL_GROUND      = 5'h1F;

	typedef enum logic [1:0] {
		ASR_GAIN_NONE,
		ASR_GAIN_1X,
		ASR_GAIN_10X,
		ASR_GAIN_200X
	} asr_gain_t;

endpackage
